//--- dv/slms_remote.sv
`timescale 1ns/1ns
module slms_remote
    import slms_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_go,
    input wire logic [7:0] i_byte,
    output slms_char_t o_rx_char,
    output logic o_rx_line
);
    // one remote partner; biased line idles high, data toggles when stale
    initial
    begin
        o_rx_char = '0;
        o_rx_line = 1'b1;
    end
    always @(negedge i_sys_clk)
    begin
        o_rx_char.valid <= i_go;
        o_rx_char.data <= i_go ? i_byte : ~o_rx_char.data;
        o_rx_line <= !i_go;
    end
endmodule : slms_remote

//--- dv/slms_serial_line_asserts.sv
`timescale 1ns/1ns
module slms_serial_line_asserts
    import slms_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire slms_cfg_t i_cfg,
    input wire slms_fsm_state_t i_state,
    input wire logic i_tx_busy,
    input wire logic i_tx_line,
    input wire logic i_rx_line,
    input wire slms_char_t i_rx_char,
    input wire logic o_tx_enable,
    input wire slms_char_t o_rx_char,
    input wire logic o_outputs_safe,
    input wire logic o_run_led,
    input wire logic o_tx_led,
    input wire logic o_rx_led
);
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);
    chk_tx_led_level: assert property (!$past(i_sys_rst) |-> o_tx_led == $past(i_tx_line))
        else $error("tx led differs from line");
    chk_rx_led_level: assert property (!$past(i_sys_rst) |-> o_rx_led == $past(i_rx_line))
        else $error("rx led differs from line");
    chk_run_lit_op: assert property ((i_state == SLMS_ST_OP) [*3] |-> o_run_led)
        else $error("run led dark in operational");
    chk_run_dark_init: assert property
        ((i_state inside {SLMS_ST_INIT, SLMS_ST_BOOT}) [*3] |-> !o_run_led)
        else $error("run led lit in init or boot");
    chk_outputs_safe_state: assert property
        (!$past(i_sys_rst) |-> o_outputs_safe == ($past(i_state) != SLMS_ST_OP))
        else $error("safe flag wrong for state");
    chk_four_wire_drive: assert property (i_cfg.four_wire_select [*2] |-> o_tx_enable)
        else $error("driver off in four-wire mode");
    chk_echo_drop_busy: assert property ((i_cfg.echo_suppress && i_tx_busy) [*2]
        ##0 i_rx_char.valid |=> !o_rx_char.valid)
        else $error("receive passed during own transmit");
    chk_echo_pass_open: assert property (!i_cfg.four_wire_select && !i_cfg.echo_suppress
        && i_rx_char.valid |=> o_rx_char == $past(i_rx_char))
        else $error("receive lost without suppression");
endmodule : slms_serial_line_asserts

//--- dv/slms_serial_line_test.sv
`timescale 1ns/1ns
module slms_serial_line_test;
    import slms_pkg::*;
    logic clk = 1'b0;
    logic rst, tx_busy, tx_line, rx_line, go, tx_rdy, tx_en, rx_en, safe, fdx;
    logic run_led, tx_led, rx_led;
    logic [7:0] rx_byte;
    slms_cfg_t cfg;
    slms_fsm_state_t state;
    slms_char_t tx_char, rx_char, rx_out;
    int mismatches, cmp_count;
    slms_serial_line u_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_cfg(cfg), .i_state(state),
        .i_tx_char(tx_char), .i_tx_busy(tx_busy), .i_tx_line(tx_line), .i_rx_line(rx_line),
        .i_rx_char(rx_char), .o_tx_ready(tx_rdy), .o_tx_enable(tx_en), .o_rx_enable(rx_en),
        .o_rx_char(rx_out), .o_outputs_safe(safe), .o_full_duplex(fdx),
        .o_run_led(run_led), .o_tx_led(tx_led), .o_rx_led(rx_led));
    slms_remote u_remote (.i_sys_clk(clk), .i_go(go), .i_byte(rx_byte),
        .o_rx_char(rx_char), .o_rx_line(rx_line));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task check(input string what, input logic [8:0] exp, input logic [8:0] got);
        cmp_count++;
        if (exp !== got)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    task send_rx(input logic [7:0] b, input logic v);
        go <= 1'b1;
        rx_byte <= b;
        step(1);
        go <= 1'b0;
        step(1);
        check("rx_led", 9'h0, {8'h0, rx_led});
        check("rx_char", v ? {1'b1, b} : 9'h0, v ? rx_out : {8'h0, rx_out.valid});
        check("rx_en", {8'h0, v}, {8'h0, rx_en});
    endtask : send_rx
    task run_case(input slms_fsm_state_t s, input logic led, input logic sf);
        state <= s;
        step(3);
        check("run_led", {8'h0, led}, {8'h0, run_led});
        check("safe", {8'h0, sf}, {8'h0, safe});
    endtask : run_case
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        rst <= 1'b1;
        step(2);
        check("reset_safe", 9'h1, {8'h0, safe});
        check("reset_leds", 9'h0, {6'h0, run_led, tx_led, rx_led});
        check("reset_ctrl", 9'h0, {5'h0, tx_rdy, tx_en, rx_en, fdx});
        check("reset_rx", 9'h0, rx_out);
        rst <= 1'b0;
    endtask : t_reset
    task t_leds;
        for (int v = 0; v < 2; v++)
        begin
            tx_line <= v[0];
            step(1);
            check("tx_led", {8'h0, v[0]}, {8'h0, tx_led});
            check("tx_ready", 9'h1, {8'h0, tx_rdy});
            check("rx_led", 9'h1, {8'h0, rx_led});
        end
    endtask : t_leds
    task t_run;
        run_case(SLMS_ST_OP, 1'b1, 1'b0);
        run_case(SLMS_ST_INIT, 1'b0, 1'b1);
        run_case(SLMS_ST_BOOT, 1'b0, 1'b1);
        // far inside the first blink half period since reset: dark phase
        run_case(SLMS_ST_PREOP, 1'b0, 1'b1);
        state <= SLMS_ST_SAFEOP;
        step(2);
        check("safe", 9'h1, {8'h0, safe});
        // still inside the first flash of the pattern
        check("run_led", 9'h1, {8'h0, run_led});
    endtask : t_run
    task t_mode;
        cfg <= 2'b10;
        step(2);
        check("duplex", 9'h1, {8'h0, fdx});
        check("tx_en", 9'h1, {8'h0, tx_en});
        cfg <= 2'b00;
        step(8);
        check("tx_en", 9'h0, {8'h0, tx_en});
        tx_char <= 9'h155;
        tx_busy <= 1'b1;
        step(1);
        tx_char <= '0;
        step(2);
        check("tx_en", 9'h1, {8'h0, tx_en});
    endtask : t_mode
    task t_echo;
        send_rx(8'ha5, 1'b1);
        cfg <= 2'b01;
        step(2);
        send_rx(8'h3c, 1'b0);
        tx_busy <= 1'b0;
        step(2);
        // transmitter still draining: receive stays closed
        send_rx(8'h0f, 1'b0);
        step(4);
        send_rx(8'hc3, 1'b1);
        cfg <= 2'b11;
        tx_busy <= 1'b1;
        step(2);
        send_rx(8'h5a, 1'b0);
        tx_busy <= 1'b0;
        step(8);
        send_rx(8'h96, 1'b1);
        cfg <= 2'b10;
        tx_busy <= 1'b1;
        step(2);
        send_rx(8'h69, 1'b1);
        check("tx_en", 9'h1, {8'h0, tx_en});
        tx_busy <= 1'b0;
    endtask : t_echo
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        rst = 1'b1;
        cfg = '0;
        state = SLMS_ST_INIT;
        tx_char = '0;
        tx_busy = 1'b0;
        tx_line = 1'b0;
        go = 1'b0;
        rx_byte = 8'h00;
        mismatches = 0;
        cmp_count = 0;
        t_reset;
        t_leds;
        t_run;
        t_reset;
        t_mode;
        t_echo;
        results;
    end
    initial
    begin
        #200000;
        mismatches++;
        results;
    end
endmodule : slms_serial_line_test
bind slms_serial_line slms_serial_line_asserts u_chk (.i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst), .i_cfg(i_cfg), .i_state(i_state), .i_tx_busy(i_tx_busy),
    .i_tx_line(i_tx_line), .i_rx_line(i_rx_line), .i_rx_char(i_rx_char),
    .o_tx_enable(o_tx_enable), .o_rx_char(o_rx_char), .o_outputs_safe(o_outputs_safe),
    .o_run_led(o_run_led), .o_tx_led(o_tx_led), .o_rx_led(o_rx_led));

//--- verilog/slms_pkg.sv
package slms_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned BLINK_HALF_MS = 200;
    localparam int unsigned FLASH_ON_MS = 200;
    localparam int unsigned FLASH_PERIOD_MS = 1200;
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int unsigned FLASH_ON_CYC = CLK_HZ / 1000 * FLASH_ON_MS;
    localparam int unsigned FLASH_PERIOD_CYC = CLK_HZ / 1000 * FLASH_PERIOD_MS;
    localparam int unsigned TMR_W = 25;

    // ------------------------------------------------------------
    // fieldbus state codes
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        SLMS_ST_INIT = 3'h1,
        SLMS_ST_PREOP = 3'h2,
        SLMS_ST_BOOT = 3'h3,
        SLMS_ST_SAFEOP = 3'h4,
        SLMS_ST_OP = 3'h0
    } slms_fsm_state_t;

    // ------------------------------------------------------------
    // configuration and line carriers
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic four_wire_select;
        logic echo_suppress;
    } slms_cfg_t;

    typedef struct packed
    {
        logic valid;
        logic [7:0] data;
    } slms_char_t;

    // ------------------------------------------------------------
    // transmit path states
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SLMS_TX_IDLE = 2'h0,
        SLMS_TX_BUSY = 2'h1,
        SLMS_TX_DRAIN = 2'h2
    } slms_tx_state_t;

    localparam logic [3:0] DRAIN_CYC = 4'h4;

endpackage : slms_pkg

//--- verilog/slms_run_led.sv
`timescale 1ns/1ns
module slms_run_led
    import slms_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire slms_fsm_state_t i_state,
    output logic o_run_led
);

    logic [TMR_W-1:0] tmr_r;
    logic [TMR_W-1:0] tmr_nxt;
    logic blink_r;
    logic run_nxt;

    // ------------------------------------------------------------
    // free running pattern timer
    // ------------------------------------------------------------
    always_comb
    begin
        if (tmr_r == TMR_W'(FLASH_PERIOD_CYC - 1))
            tmr_nxt = '0;
        else
            tmr_nxt = tmr_r + TMR_W'(1);
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
            tmr_r <= '0;
        else
            tmr_r <= tmr_nxt;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
            blink_r <= 1'b0;
        else if ((tmr_r % TMR_W'(BLINK_HALF_CYC)) == TMR_W'(BLINK_HALF_CYC - 1))
            blink_r <= ~blink_r;
    end

    // ------------------------------------------------------------
    // state to pattern
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (i_state)
            SLMS_ST_INIT: run_nxt = 1'b0;
            SLMS_ST_BOOT: run_nxt = 1'b0;
            SLMS_ST_PREOP: run_nxt = blink_r;
            SLMS_ST_SAFEOP: run_nxt = (tmr_r < TMR_W'(FLASH_ON_CYC));
            SLMS_ST_OP: run_nxt = 1'b1;
            default: run_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
            o_run_led <= 1'b0;
        else
            o_run_led <= run_nxt;
    end

endmodule : slms_run_led

//--- verilog/slms_serial_line.sv
`timescale 1ns/1ns
module slms_serial_line
    import slms_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire slms_cfg_t i_cfg,
    input wire slms_fsm_state_t i_state,
    input wire slms_char_t i_tx_char,
    input wire logic i_tx_busy,
    input wire logic i_tx_line,
    input wire logic i_rx_line,
    input wire slms_char_t i_rx_char,
    output logic o_tx_ready,
    output logic o_tx_enable,
    output logic o_rx_enable,
    output slms_char_t o_rx_char,
    output logic o_outputs_safe,
    output logic o_full_duplex,
    output logic o_run_led,
    output logic o_tx_led,
    output logic o_rx_led
);

    slms_tx_state_t tx_state_r;
    slms_tx_state_t tx_state_nxt;
    logic [3:0] drain_r;
    logic tx_active;
    logic rx_gate;
    logic echo_drop;
    logic full_duplex;

    assign full_duplex = i_cfg.four_wire_select;
    assign tx_active = (tx_state_r != SLMS_TX_IDLE);

    // ------------------------------------------------------------
    // transmit activity tracking
    // ------------------------------------------------------------
    always_comb
    begin
        tx_state_nxt = tx_state_r;
        unique case (tx_state_r)
            SLMS_TX_IDLE:
            begin
                if (i_tx_char.valid || i_tx_busy)
                    tx_state_nxt = SLMS_TX_BUSY;
            end
            SLMS_TX_BUSY:
            begin
                if (!i_tx_busy && !i_tx_char.valid)
                    tx_state_nxt = SLMS_TX_DRAIN;
            end
            SLMS_TX_DRAIN:
            begin
                if (i_tx_char.valid || i_tx_busy)
                    tx_state_nxt = SLMS_TX_BUSY;
                else if (drain_r == DRAIN_CYC)
                    tx_state_nxt = SLMS_TX_IDLE;
            end
            default: tx_state_nxt = SLMS_TX_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
            tx_state_r <= SLMS_TX_IDLE;
        else
            tx_state_r <= tx_state_nxt;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst || tx_state_r != SLMS_TX_DRAIN)
            drain_r <= '0;
        else
            drain_r <= drain_r + 4'h1;
    end

    // ------------------------------------------------------------
    // mode decisions
    // ------------------------------------------------------------
    always_comb
    begin
        if (full_duplex)
            rx_gate = !(i_cfg.echo_suppress && tx_active);
        else
            rx_gate = !tx_active || !i_cfg.echo_suppress;
    end

    // own echo recognised only in two-wire mode, while our own frame is on the line or draining
    assign echo_drop = !full_duplex && i_cfg.echo_suppress && tx_active;

    // ------------------------------------------------------------
    // line control outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            o_tx_enable <= 1'b0;
            o_tx_ready <= 1'b0;
            o_full_duplex <= 1'b0;
        end
        else
        begin
            o_tx_enable <= full_duplex || tx_active || i_tx_char.valid;
            o_tx_ready <= 1'b1;
            o_full_duplex <= full_duplex;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
            o_rx_enable <= 1'b0;
        else
            o_rx_enable <= rx_gate && !echo_drop;
    end

    // ------------------------------------------------------------
    // receive data path
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
            o_rx_char <= '0;
        else
        begin
            o_rx_char.data <= i_rx_char.data;
            o_rx_char.valid <= i_rx_char.valid && rx_gate && !echo_drop;
        end
    end

    // ------------------------------------------------------------
    // line level indicators and safe outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            o_tx_led <= 1'b0;
            o_rx_led <= 1'b0;
            o_outputs_safe <= 1'b1;
        end
        else
        begin
            o_tx_led <= i_tx_line;
            o_rx_led <= i_rx_line;
            o_outputs_safe <= (i_state != SLMS_ST_OP);
        end
    end

    // ------------------------------------------------------------
    // run indicator
    // ------------------------------------------------------------
    slms_run_led u_run_led
    (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_state(i_state),
        .o_run_led(o_run_led)
    );

endmodule : slms_serial_line
